// [sapc_map.svh]
// timing and width constants for the converter power and conversion control
`ifndef SAPC_MAP_SVH
`define SAPC_MAP_SVH
`define SAPC_CLK_MHZ      100
`define SAPC_PWRUP_NS     1500
`define SAPC_PWRUP_CYC    ((`SAPC_PWRUP_NS * `SAPC_CLK_MHZ + 999) / 1000)
`define SAPC_CONV_MAX_NS  5000
`define SAPC_CONV_MAX_CYC ((`SAPC_CONV_MAX_NS * `SAPC_CLK_MHZ) / 1000)
`define SAPC_BITS         8
`define SAPC_STEP_DIV     50
`define SAPC_MSB_MASK     8'h80
`endif

// [sapc_pkg.sv]
// types for the converter power and conversion control
package sapc_pkg;
	typedef enum logic [3:0] {
		SAPC_PDOWN = 4'h1,
		SAPC_WAKE  = 4'h2,
		SAPC_TRACK = 4'h4,
		SAPC_CONV  = 4'h8
	} sapc_state_t;
endpackage

// [sapc_step_gen.sv]
// divider giving the internal oscillator step enable
`timescale 1ns/1ps
`include "sapc_map.svh"
module sapc_step_gen #(
	parameter int DIV = `SAPC_STEP_DIV
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	output logic      step
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        step;
	} sapc_div_t;
	sapc_div_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.step = 1'b0;
		if (!run) begin
			s_d.cnt = 16'h0000;
		end else if (s_q.cnt == 16'(DIV - 1)) begin
			s_d.cnt = 16'h0000;
			s_d.step = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign step = s_q.step;
endmodule

// [sapc_ctrl.sv]
// power and successive-approximation sequencing of the 8-bit converter
// Notes on behaviour
// - after reset the converter sits powered down and does not convert
// - rising convert-start wakes the converter; power-up takes 1.5 us
// - falling convert-start puts track/hold into hold and starts conversion
// - after a conversion with convert-start high, return to track until next falling edge
// - result is 8-bit straight binary, step is reference over 256
// - rising convert-start enables the serial port; no shifting before it
// - automatic power-down at conversion end until the next rising edge
// - convert-start sampled at conversion end: high stays up, low powers down
// - conversion ends within 5 us; result latched into shift register
// - early falling edge waits out power-up then converts automatically
`timescale 1ns/1ps
`include "sapc_map.svh"
module sapc_ctrl
	import sapc_pkg::*;
#(
	parameter int BITS      = `SAPC_BITS,
	parameter int PWRUP_CYC = `SAPC_PWRUP_CYC,
	parameter int STEP_DIV  = `SAPC_STEP_DIV
) (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            convert_start_n,
	input  wire logic            comp_high,
	output logic                 powered,
	output logic                 hold,
	output logic                 busy,
	output logic [BITS-1:0]      dac_code,
	output logic [BITS-1:0]      result,
	output logic                 result_load,
	output logic                 serial_enable
);
	// =========================================================
	// state
	typedef struct packed {
		logic [2:0]      sync;
		sapc_state_t     st;
		logic [15:0]     wait_cnt;
		logic            start_pend;
		logic [BITS-1:0] trial;
		logic [BITS-1:0] mask;
		logic            powered;
		logic            hold;
		logic            busy;
		logic [BITS-1:0] result;
		logic            result_load;
		logic            serial_enable;
	} sapc_ctrl_t;

	sapc_ctrl_t s_q, s_d;
	logic       step;
	logic       rise;
	logic       fall;
	logic       level;

	sapc_step_gen #(
		.DIV(STEP_DIV)
	) u_step (
		.clk_sys(clk_sys),
		.rst    (rst),
		.run    (s_q.st == SAPC_CONV),
		.step   (step)
	);

	// only stages two and three are compared; stage one is metastability catch
	assign level = s_q.sync[2];
	assign rise  = s_q.sync[1] & ~s_q.sync[2];
	assign fall  = ~s_q.sync[1] & s_q.sync[2];

	// =========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], convert_start_n};
		s_d.result_load = 1'b0;
		if (rise) begin
			s_d.serial_enable = 1'b1;
		end
		case (s_q.st)
			SAPC_PDOWN: begin
				s_d.powered = 1'b0;
				s_d.hold = 1'b0;
				if (rise) begin
					s_d.st = SAPC_WAKE;
					s_d.wait_cnt = 16'h0000;
					s_d.start_pend = 1'b0;
				end
			end
			SAPC_WAKE: begin
				s_d.powered = 1'b1;
				if (fall) begin
					s_d.start_pend = 1'b1;
				end
				if (s_q.wait_cnt >= 16'(PWRUP_CYC - 1)) begin
					if (s_q.start_pend || fall) begin
						s_d.st = SAPC_CONV;
						s_d.hold = 1'b1;
						s_d.busy = 1'b1;
						s_d.trial = BITS'(`SAPC_MSB_MASK);
						s_d.mask = BITS'(`SAPC_MSB_MASK);
					end else begin
						s_d.st = SAPC_TRACK;
					end
				end else begin
					s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
				end
			end
			SAPC_TRACK: begin
				s_d.hold = 1'b0;
				if (fall) begin
					s_d.st = SAPC_CONV;
					s_d.hold = 1'b1;
					s_d.busy = 1'b1;
					s_d.trial = BITS'(`SAPC_MSB_MASK);
					s_d.mask = BITS'(`SAPC_MSB_MASK);
				end
			end
			SAPC_CONV: begin
				if (step) begin
					// comparator high means trial exceeds input: drop the bit
					if (comp_high) begin
						s_d.trial = s_q.trial & ~s_q.mask;
					end
					s_d.mask = s_q.mask >> 1;
					if (s_q.mask[0]) begin
						s_d.result = comp_high ? (s_q.trial & ~s_q.mask) : s_q.trial;
						s_d.result_load = 1'b1;
						s_d.busy = 1'b0;
						s_d.hold = 1'b0;
						if (level) begin
							s_d.st = SAPC_TRACK;
						end else begin
							s_d.st = SAPC_PDOWN;
							s_d.powered = 1'b0;
						end
					end else begin
						s_d.trial = (comp_high ? (s_q.trial & ~s_q.mask) : s_q.trial)
							| (s_q.mask >> 1);
					end
				end
			end
			default: begin
				s_d.st = SAPC_PDOWN;
			end
		endcase
	end

	// =========================================================
	// registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= SAPC_PDOWN;
		end else begin
			s_q <= s_d;
		end
	end

	assign powered       = s_q.powered;
	assign hold          = s_q.hold;
	assign busy          = s_q.busy;
	assign dac_code      = s_q.trial;
	assign result        = s_q.result;
	assign result_load   = s_q.result_load;
	assign serial_enable = s_q.serial_enable;
endmodule

// [sapc_ctrl_sva.sv]
// assertions on the converter control ports
`timescale 1ns/1ps
module sapc_ctrl_sva #(parameter int BITS = 8, parameter int STEP_DIV = 50) (
	input logic            clk_sys, rst, convert_start_n, comp_high, powered, hold, busy,
	input logic [BITS-1:0] dac_code, result,
	input logic            result_load, serial_enable
);
	localparam int CMAX = 8 * STEP_DIV + 8;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	idle_off_a: assert property ($fell(rst) |-> !powered && !busy) else $error("awake");
	wake_up_a: assert property ($rose(convert_start_n) && !powered |-> ##[2:5] powered)
		else $error("no wake");
	hold_busy_a: assert property (hold == busy) else $error("hold");
	msb_first_a: assert property ($rose(busy) |-> dac_code == 8'h80) else $error("msb");
	conv_bound_a: assert property ($rose(busy) |-> ##[1:CMAX] result_load)
		else $error("slow");
	load_pulse_a: assert property (result_load |=> !result_load && !hold) else $error("load");
	// sync delay: pin must have been low well before the end
	auto_pd_a: assert property (result_load && !convert_start_n && !$past(convert_start_n, 4)
		|-> ##[0:1] !powered) else $error("pd");
	port_en_a: assert property ($rose(serial_enable) |-> $past(convert_start_n, 2))
		else $error("port");
endmodule
bind sapc_ctrl sapc_ctrl_sva #(.BITS(BITS), .STEP_DIV(STEP_DIV)) u_sva(.clk_sys, .rst,
	.convert_start_n, .comp_high, .powered, .hold, .busy, .dac_code, .result, .result_load,
	.serial_enable);

// [sapc_afe.sv]
// comparator stand-in, analog input given as a code
`timescale 1ns/1ps
module sapc_afe (
	input  logic [7:0] dac_code,
	input  logic [7:0] vin,
	output logic       comp_high
);
	assign comp_high = dac_code > vin;
endmodule

// [tb.sv]
// self-checking bench for the converter control
`timescale 1ns/1ps
module tb;
	logic       clk_sys = 0, rst = 1, convert_start_n = 0, comp_high, powered, hold, busy;
	logic       result_load, serial_enable;
	logic [7:0] vin = 0, dac_code, result;
	int         fail_count = 0, comparisons = 0, cyc = 0;
	always #5 clk_sys = ~clk_sys;
	// short counts keep the run brief
	sapc_ctrl #(.PWRUP_CYC(20), .STEP_DIV(2)) u_dut(.clk_sys, .rst, .convert_start_n,
		.comp_high, .powered, .hold, .busy, .dac_code, .result, .result_load, .serial_enable);
	sapc_afe u_afe(.dac_code, .vin, .comp_high);
	task automatic give_verdict;
		$display("checks %0d errors %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conv(logic [7:0] v, int gap, logic keep);
		int n;
		@(posedge clk_sys);
		vin <= v;
		convert_start_n <= 1'b1;
		repeat (gap) @(posedge clk_sys);
		convert_start_n <= 1'b0;
		if (keep) begin
			repeat (6) @(posedge clk_sys);
			convert_start_n <= 1'b1;
		end
		for (n = 0; n < 400 && result_load !== 1'b1; n++) @(negedge clk_sys);
		chk("result", v, result);
		repeat (4) @(negedge clk_sys);
		chk("powered", {7'h0, keep}, {7'h0, powered});
		repeat (12) @(negedge clk_sys);
	endtask
	task automatic t_auto;
		conv(8'ha5, 30, 1'b0);
	endtask
	task automatic t_early;
		conv(8'hff, 4, 1'b0);
	endtask
	task automatic t_fast;
		conv(8'h00, 30, 1'b1);
		conv(8'h01, 30, 1'b1);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("idle", 8'h0, {powered, busy, serial_enable});
		t_auto();
		t_early();
		t_fast();
		chk("port", 8'h1, {7'h0, serial_enable});
		give_verdict;
	end
endmodule
